// file: hw/stage_config_field_decode.sv
`timescale 1ns/1ps
`default_nettype none

module stage_config_field_decode
    import stage_cfg_pkg::*;
#(
    parameter int N_STAGES = NUM_STAGES
) (
    input  wire logic               mclk_i,
    input  wire logic               reset_n_i,
    input  wire logic [ADDR_W-1:0]  reg_addr_i,
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    input  wire logic [WORD_W-1:0]  reg_wdata_i,
    output logic      [WORD_W-1:0]  reg_rdata_o,
    output logic                    reg_rvalid_o,
    input  wire logic [3:0]         stage_sel_i,
    output logic                    stage_valid_o,
    output stage_drive_s            drive_o
);

    function automatic logic [2:0] route_decode(input logic [1:0] code);
        // returns {bias, plus, minus}
        logic [2:0] r;
        r = 3'h0;
        unique case (code)
            ROUTE_OPEN:  r = 3'h0;
            ROUTE_MINUS: r = 3'h1;
            ROUTE_PLUS:  r = 3'h2;
            ROUTE_BIAS:  r = 3'h4;
        endcase
        return r;
    endfunction : route_decode

    function automatic logic [13:0] thresh_pct(input logic [3:0] code);
        logic [13:0] p;
        p = 14'd2500;
        unique case (code)
            4'h0: p = 14'd2500;
            4'h1: p = 14'd2973;
            4'h2: p = 14'd3440;
            4'h3: p = 14'd3908;
            4'h4: p = 14'd4379;
            4'h5: p = 14'd4847;
            4'h6: p = 14'd5315;
            4'h7: p = 14'd5783;
            4'h8: p = 14'd6251;
            4'h9: p = 14'd6722;
            4'ha: p = 14'd7190;
            4'hb: p = 14'd7658;
            4'hc: p = 14'd8128;
            4'hd: p = 14'd8596;
            4'he: p = 14'd9064;
            4'hf: p = 14'd9532;
        endcase
        return p;
    endfunction : thresh_pct

    function automatic logic [14:0] peak_pct(input logic [2:0] code);
        // returns {valid, level}; reserved codes give level 0, valid 0
        logic [14:0] r;
        logic [13:0] prod;
        prod = 14'(code * PEAK_STEP_PCT);
        r = 15'h0;
        if (code <= PEAK_MAX_CODE) begin
            r = {1'b1, 14'(PEAK_BASE_PCT + prod)};
        end
        return r;
    endfunction : peak_pct

    // register storage, no reset on purpose
    stage_cfg_s cfg_r [N_STAGES];

    // address decode
    wire logic [ADDR_W-1:0] rel_addr    = reg_addr_i - STAGE_BASE;
    wire logic [3:0]        acc_stage   = rel_addr[6:3];
    wire logic [2:0]        acc_word    = rel_addr[2:0];
    wire logic              in_range    = (reg_addr_i >= STAGE_BASE) &&
                                          (rel_addr[ADDR_W-1:7] == '0) &&
                                          (int'(acc_stage) < N_STAGES);
    wire logic              word_hit    = (acc_word == OFS_ROUTE_LO) ||
                                          (acc_word == OFS_ROUTE_HI) ||
                                          (acc_word == OFS_OFFSET) ||
                                          (acc_word == OFS_SENS);
    wire logic              hit         = in_range && word_hit;
    wire logic              wr_hit      = reg_wr_i && hit;

    // read mux
    stage_cfg_s             acc_cfg;
    logic [WORD_W-1:0]      rd_word;
    assign acc_cfg = in_range ? cfg_r[acc_stage] : '0;
    always_comb begin
        rd_word = '0;
        if (hit) begin
            unique case (acc_word)
                OFS_ROUTE_LO: rd_word = acc_cfg.route_lo;
                OFS_ROUTE_HI: rd_word = acc_cfg.route_hi;
                OFS_OFFSET:   rd_word = acc_cfg.offset;
                OFS_SENS:     rd_word = acc_cfg.sens;
                default:      rd_word = '0;
            endcase
        end
    end

    // register writes; sensitivity stored as written, software keeps unused bits at zero
    always_ff @(posedge mclk_i) begin
        if (wr_hit) begin
            unique case (acc_word)
                OFS_ROUTE_LO: cfg_r[acc_stage].route_lo <= reg_wdata_i;
                OFS_ROUTE_HI: cfg_r[acc_stage].route_hi <= reg_wdata_i;
                OFS_OFFSET:   cfg_r[acc_stage].offset   <= reg_wdata_i;
                OFS_SENS:     cfg_r[acc_stage].sens     <= reg_wdata_i;
                default:      ;
            endcase
        end
    end

    // selected stage decode
    wire logic              sel_ok  = int'(stage_sel_i) < N_STAGES;
    stage_cfg_s             sel_cfg;
    assign sel_cfg = sel_ok ? cfg_r[stage_sel_i] : '0;

    logic [27:0]            route_all;
    assign route_all = {sel_cfg.route_hi[13:0], sel_cfg.route_lo[13:0]};

    logic [NUM_INPUTS-1:0]  to_minus;
    logic [NUM_INPUTS-1:0]  to_plus;
    logic [NUM_INPUTS-1:0]  to_bias;

    for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_route
        wire logic [2:0] dec = route_decode(route_all[2*i +: 2]);
        assign to_minus[i] = dec[0];
        assign to_plus[i]  = dec[1];
        assign to_bias[i]  = dec[2];
    end

    wire logic [14:0] minus_peak = peak_pct(sel_cfg.sens[MINUS_PEAK_LSB +: PEAK_W]);
    wire logic [14:0] plus_peak  = peak_pct(sel_cfg.sens[PLUS_PEAK_LSB +: PEAK_W]);

    stage_drive_s drive_nxt;
    always_comb begin
        drive_nxt                      = '0;
        drive_nxt.to_minus             = to_minus;
        drive_nxt.to_plus              = to_plus;
        drive_nxt.to_bias              = to_bias;
        drive_nxt.minus_offset_on      = ~sel_cfg.route_hi[MINUS_OFF_BIT];
        drive_nxt.plus_offset_on       = ~sel_cfg.route_hi[PLUS_OFF_BIT];
        drive_nxt.minus_offset_code    = sel_cfg.offset[MINUS_CODE_LSB +: OFFSET_CODE_W];
        drive_nxt.minus_offset_to_plus = sel_cfg.offset[MINUS_STEER_BIT];
        drive_nxt.plus_offset_code     = sel_cfg.offset[PLUS_CODE_LSB +: OFFSET_CODE_W];
        drive_nxt.plus_offset_to_minus = sel_cfg.offset[PLUS_STEER_BIT];
        drive_nxt.minus_thresh_pct     = thresh_pct(sel_cfg.sens[MINUS_SENS_LSB +: SENS_W]);
        drive_nxt.plus_thresh_pct      = thresh_pct(sel_cfg.sens[PLUS_SENS_LSB +: SENS_W]);
        drive_nxt.minus_peak_pct       = minus_peak[13:0];
        drive_nxt.minus_peak_ok        = minus_peak[14];
        drive_nxt.plus_peak_pct        = plus_peak[13:0];
        drive_nxt.plus_peak_ok         = plus_peak[14];
    end

    // output registers
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o   <= '0;
            reg_rvalid_o  <= 1'b0;
            stage_valid_o <= 1'b0;
            drive_o       <= '0;
        end else begin
            reg_rdata_o   <= reg_rd_i ? rd_word : '0;
            reg_rvalid_o  <= reg_rd_i;
            stage_valid_o <= sel_ok;
            drive_o       <= sel_ok ? drive_nxt : '0;
        end
    end

endmodule : stage_config_field_decode

`default_nettype wire

// file: hw/stage_cfg_pkg.sv
package stage_cfg_pkg;

    localparam int           NUM_STAGES     = 12;
    localparam int           NUM_INPUTS     = 14;
    localparam int           ADDR_W         = 10;
    localparam int           WORD_W         = 16;
    localparam int           PCT_W          = 14;

    // stage x occupies eight consecutive word addresses from STAGE_BASE + 8*x
    localparam logic [9:0]   STAGE_BASE     = 10'h080;
    localparam int           STAGE_STRIDE   = 8;
    localparam logic [2:0]   OFS_ROUTE_LO   = 3'h0;
    localparam logic [2:0]   OFS_ROUTE_HI   = 3'h1;
    localparam logic [2:0]   OFS_OFFSET     = 3'h2;
    localparam logic [2:0]   OFS_SENS       = 3'h3;

    // routing codes
    localparam logic [1:0]   ROUTE_OPEN     = 2'h0;
    localparam logic [1:0]   ROUTE_MINUS    = 2'h1;
    localparam logic [1:0]   ROUTE_PLUS     = 2'h2;
    localparam logic [1:0]   ROUTE_BIAS     = 2'h3;
    localparam int           INPUTS_PER_WORD = 7;
    localparam int           HI_FIRST_INPUT = 7;

    // offset-disable bits of the upper routing word
    localparam int           MINUS_OFF_BIT  = 14;
    localparam int           PLUS_OFF_BIT   = 15;

    // offset word fields
    localparam int           MINUS_CODE_LSB = 0;
    localparam int           MINUS_STEER_BIT = 7;
    localparam int           PLUS_CODE_LSB  = 8;
    localparam int           PLUS_STEER_BIT = 15;
    localparam int           OFFSET_CODE_W  = 7;
    localparam int           OFFSET_LSB_FF  = 160;     // femtofarads per count
    localparam int           OFFSET_SPAN_FF = 20000;   // femtofarads

    // sensitivity word fields
    localparam int           MINUS_SENS_LSB = 0;
    localparam int           MINUS_PEAK_LSB = 4;
    localparam int           PLUS_SENS_LSB  = 8;
    localparam int           PLUS_PEAK_LSB  = 12;
    localparam int           SENS_W         = 4;
    localparam int           PEAK_W         = 3;

    // peak levels in hundredths of a percent
    localparam logic [13:0]  PEAK_BASE_PCT  = 14'd4000;
    localparam logic [13:0]  PEAK_STEP_PCT  = 14'd1000;
    localparam logic [2:0]   PEAK_MAX_CODE  = 3'h5;

    typedef struct packed {
        logic [15:0] sens;
        logic [15:0] offset;
        logic [15:0] route_hi;
        logic [15:0] route_lo;
    } stage_cfg_s;

    typedef struct packed {
        logic [13:0] to_minus;
        logic [13:0] to_plus;
        logic [13:0] to_bias;
        logic        minus_offset_on;
        logic        minus_offset_to_plus;
        logic [6:0]  minus_offset_code;
        logic        plus_offset_on;
        logic        plus_offset_to_minus;
        logic [6:0]  plus_offset_code;
        logic [13:0] minus_thresh_pct;
        logic [13:0] plus_thresh_pct;
        logic [13:0] minus_peak_pct;
        logic        minus_peak_ok;
        logic [13:0] plus_peak_pct;
        logic        plus_peak_ok;
    } stage_drive_s;

endpackage : stage_cfg_pkg

// file: verif/stage_cfg_props.sv
`timescale 1ns/1ps
`default_nettype none
module stage_cfg_props
    import stage_cfg_pkg::*;
#(
    parameter int N_STAGES = NUM_STAGES
) (
    input wire logic               mclk_i,
    input wire logic               reset_n_i,
    input wire logic [ADDR_W-1:0]  reg_addr_i,
    input wire logic               reg_wr_i,
    input wire logic               reg_rd_i,
    input wire logic [WORD_W-1:0]  reg_wdata_i,
    input wire logic [WORD_W-1:0]  reg_rdata_o,
    input wire logic               reg_rvalid_o,
    input wire logic [3:0]         stage_sel_i,
    input wire logic               stage_valid_o,
    input wire stage_drive_s       drive_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    wire unmapped = reg_addr_i < 10'h080 || reg_addr_i > 10'h0df || reg_addr_i[2];
    sequence quiet_s;
        !reg_wr_i && $stable(stage_sel_i);
    endsequence
    a_rd_answers: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read strobe without rvalid");
    a_no_stray_rvalid: assert property (!reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == '0)
        else $error("rvalid or rdata without read");
    a_unmapped_zero: assert property (reg_rd_i && unmapped |=> reg_rdata_o == '0)
        else $error("unmapped read not zero");
    a_stage_valid: assert property (stage_sel_i < N_STAGES |=> stage_valid_o)
        else $error("stage valid missing");
    a_stage_refused: assert property (stage_sel_i >= N_STAGES |=> !stage_valid_o && drive_o == '0)
        else $error("out of range stage drives");
    a_route_exclusive: assert property (stage_valid_o |-> ((drive_o.to_minus & drive_o.to_plus) |
        (drive_o.to_bias & (drive_o.to_minus | drive_o.to_plus))) == '0)
        else $error("input routed twice");
    a_peak_reserved: assert property (stage_valid_o && !drive_o.minus_peak_ok |-> drive_o.minus_peak_pct == '0)
        else $error("reserved peak code gives level");
    a_peak_step: assert property (drive_o.plus_peak_ok |-> drive_o.plus_peak_pct inside
        {14'd4000, 14'd5000, 14'd6000, 14'd7000, 14'd8000, 14'd9000})
        else $error("peak level off table");
    a_thresh_span: assert property (stage_valid_o |-> drive_o.minus_thresh_pct inside {[2500:9532]})
        else $error("threshold out of span");
    a_drive_holds: assert property (quiet_s ##1 quiet_s |=> $stable(drive_o))
        else $error("drive changed without cause");
endmodule : stage_cfg_props
bind stage_config_field_decode stage_cfg_props #(.N_STAGES(N_STAGES)) props_u (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .stage_sel_i(stage_sel_i), .stage_valid_o(stage_valid_o),
    .drive_o(drive_o));
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import stage_cfg_pkg::*;
    localparam int THR [16] = '{2500, 2973, 3440, 3908, 4379, 4847, 5315, 5783,
                                6251, 6722, 7190, 7658, 8128, 8596, 9064, 9532};
    logic         mclk_i = 1'b0;
    logic         reset_n_i = 1'b0;
    logic [9:0]   reg_addr_i = '0;
    logic         reg_wr_i = 1'b0;
    logic         reg_rd_i = 1'b0;
    logic [15:0]  reg_wdata_i = '0;
    logic [15:0]  reg_rdata_o;
    logic         reg_rvalid_o;
    logic [3:0]   stage_sel_i = 4'hf;
    logic         stage_valid_o;
    stage_drive_s drive_o;
    logic [15:0]  mem [int];
    logic [15:0]  w;
    int           bad_count = 0;
    int           total_checks = 0;
    always #25 mclk_i = ~mclk_i;
    stage_config_field_decode #(.N_STAGES(NUM_STAGES)) dut_u (.mclk_i(mclk_i),
        .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .stage_sel_i(stage_sel_i), .stage_valid_o(stage_valid_o), .drive_o(drive_o));
    task automatic chk_w(string n, logic [15:0] e, logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk_w
    task automatic chk_d(stage_drive_s e, stage_drive_s g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] drive_o expected %h seen %h", e, g);
        end
    endtask : chk_d
    function automatic stage_drive_s exp_drive(int s);
        stage_drive_s d;
        logic [27:0]  rt;
        logic [15:0]  of;
        logic [15:0]  sn;
        int           a;
        d = '0;
        if (s >= NUM_STAGES) return d;
        a = 128 + 8 * s;
        rt = {mem[a+1][13:0], mem[a][13:0]};
        of = mem[a+2];
        sn = mem[a+3];
        for (int i = 0; i < 14; i++) begin
            d.to_minus[i] = rt[2*i+:2] == 2'h1;
            d.to_plus[i] = rt[2*i+:2] == 2'h2;
            d.to_bias[i] = rt[2*i+:2] == 2'h3;
        end
        d.minus_offset_on = ~mem[a+1][14];
        d.plus_offset_on = ~mem[a+1][15];
        d.minus_offset_to_plus = of[7];
        d.minus_offset_code = of[6:0];
        d.plus_offset_to_minus = of[15];
        d.plus_offset_code = of[14:8];
        d.minus_thresh_pct = 14'(THR[sn[3:0]]);
        d.plus_thresh_pct = 14'(THR[sn[11:8]]);
        d.minus_peak_ok = sn[6:4] < 3'h6;
        d.plus_peak_ok = sn[14:12] < 3'h6;
        d.minus_peak_pct = d.minus_peak_ok ? 14'(4000 + 1000 * sn[6:4]) : '0;
        d.plus_peak_pct = d.plus_peak_ok ? 14'(4000 + 1000 * sn[14:12]) : '0;
        return d;
    endfunction : exp_drive
    task automatic wr(logic [9:0] a, logic [15:0] d);
        @(posedge mclk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
        if (a >= 10'h080 && a <= 10'h0df && !a[2]) mem[int'(a)] = d;
    endtask : wr
    task automatic rd(logic [9:0] a);
        @(posedge mclk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk_w("reg_rvalid_o", 16'h1, {15'h0, reg_rvalid_o});
        chk_w("reg_rdata_o", mem.exists(int'(a)) ? mem[int'(a)] : 16'h0, reg_rdata_o);
    endtask : rd
    task automatic look(int s, int n);
        repeat (n) @(posedge mclk_i);
        #1;
        chk_d(exp_drive(s), drive_o);
        chk_w("stage_valid_o", {15'h0, s < NUM_STAGES}, {15'h0, stage_valid_o});
    endtask : look
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        void'($urandom(32'hb7c2));
        repeat (6) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        for (int s = 0; s < NUM_STAGES; s++) begin
            for (int k = 0; k < 4; k++) begin
                w = 16'($urandom);
                if (k == 3) w = {1'b0, w[14:8], 1'b0, 3'(s), w[3:0]};
                wr(10'(128 + 8 * s + k), w);
            end
        end
        for (int s = 0; s < NUM_STAGES; s++) begin
            for (int k = 0; k < 8; k++) rd(10'(128 + 8 * s + k));
        end
        wr(10'h0e0, 16'h1234);
        rd(10'h0e0);
        rd(10'h07f);
        for (int s = 0; s < 16; s++) begin
            @(posedge mclk_i);
            stage_sel_i <= 4'(s);
            look(s, 1);
        end
        @(posedge mclk_i);
        stage_sel_i <= 4'h5;
        wr(10'h0ab, 16'h6a5c);
        look(5, 2);
        wr(10'h0ab, 16'h5f70);
        look(5, 2);
        wr(10'h084, 16'h4321);
        rd(10'h084);
        @(posedge mclk_i);
        reset_n_i <= 1'b0;
        #1;
        chk_d('0, drive_o);
        chk_w("stage_valid_o", 16'h0, {15'h0, stage_valid_o});
        @(posedge mclk_i);
        reset_n_i <= 1'b1;
        look(5, 2);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
